// file: pkg/led_sink_pkg.sv
/*
 Constants for the serial LED sink controller: channel count, synchroniser
 depth and reset values. Assumes a single 10 MHz system clock.
*/
package led_sink_pkg;
   // ----------------------------------------
   // Geometry and reset values
   // ----------------------------------------
   localparam int unsigned CHAN_COUNT = 16;
   localparam int unsigned SYNC_STAGES = 3;
   localparam logic [15:0] SHIFT_RESET = 16'h0000;
   localparam logic [15:0] LATCH_RESET = 16'h0000;
   localparam logic [2:0] SYNC_RESET = 3'h0;
   localparam logic SYNC_HIGH_RESET = 1'b1;
   localparam logic [15:0] SINK_RESET = 16'hffff;
   localparam logic SOUT_RESET = 1'b0;
   localparam logic CLK_PREV_RESET = 1'b0;
   // Positions of the host pins in the synchroniser vector
   localparam int unsigned PIN_COUNT = 4;
   localparam int unsigned PIN_SCLK = 0;
   localparam int unsigned PIN_DATA = 1;
   localparam int unsigned PIN_STROBE = 2;
   localparam int unsigned PIN_DISABLE = 3;
   // Host shift clock ceiling, and the system clock that samples the host pins
   localparam int unsigned SHIFT_CLK_MAX_MHZ = 30;
   localparam int unsigned SYS_CLK_MHZ = 10;
   localparam int unsigned SYS_CLK_PERIOD_NS = 100;
endpackage

// file: src/pin_sync.sv
/*
 Three-flop pin synchroniser with agreement filter.
 Assumes an asynchronous pin input and the system clock.
*/
`timescale 1ns/1ps
module pin_sync
   import led_sink_pkg::*;
#(
   parameter logic RESET_VAL = 1'b0
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Pin and filtered level
   input wire logic pin_i,
   output logic level_o
);
   typedef struct packed {
      logic [2:0] stage;
      logic level;
   } sync_state_t;

   sync_state_t st_q;
   sync_state_t st_d;

   // ----------------------------------------
   // Filter
   // ----------------------------------------
   // Stage 0 only feeds stage 1; level moves only when stages 1 and 2 agree
   always_comb begin
      st_d = st_q;
      st_d.stage = {st_q.stage[1:0], pin_i};
      if (st_q.stage[1] == st_q.stage[2]) begin
         st_d.level = st_q.stage[2];
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q <= {{3{RESET_VAL}}, RESET_VAL};
      end else begin
         st_q <= st_d;
      end
   end

   assign level_o = st_q.level;

   chk_level_agree: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !$stable(st_q.level) |-> $past(st_q.stage[1]) == $past(st_q.stage[2]) && st_q.level == $past(st_q.stage[2]))
      else $error("filtered level moved without agreement");
endmodule

// file: src/led_sink_shift_latch.sv
/*
 Serial-in, parallel-out control logic of a 16-channel LED sink driver.
 Assumes host pins (shift clock, data, strobe, enable) are asynchronous and
 sampled by the 10 MHz system clock; the host shift clock must be below
 a quarter of that rate, each phase over two cycles, for every edge to be seen.
 Limitation: each pin passes a three-flop filter, so a pulse shorter than two
 system clock cycles can be lost and nothing reports it. The trade is a
 slower host rate for immunity to metastability on every pin.
 All four pins use the same filter depth, so data and shift clock keep
 their relative timing on the way in.
*/
`timescale 1ns/1ps
module led_sink_shift_latch
   import led_sink_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rstn_i,
   // Host pins
   input wire logic shift_clk_i,
   input wire logic serial_bit_in_i,
   input wire logic latch_load_strobe_i,
   input wire logic output_disable_i,
   // Device pins
   output logic serial_bit_out_o,
   output logic [15:0] sink_on_n_o
);
   // ----------------------------------------
   // State
   // ----------------------------------------
   typedef struct packed {
      logic clk_prev;
      logic [15:0] shift;
      logic [15:0] latch;
      logic sout;
      logic [15:0] sink_n;
   } core_state_t;

   core_state_t st_q;
   core_state_t st_d;
   // Raw and filtered host pins, indexed by the pin positions of the package
   logic [PIN_COUNT-1:0] pin_raw;
   logic [PIN_COUNT-1:0] pin_s;
   logic sclk_s;
   logic data_s;
   logic strobe_s;
   logic oe_n_s;
   logic shift_edge;

   // ----------------------------------------
   // Output decode
   // ----------------------------------------
   // Sink pattern for a latched word: a set bit sinks current, disable wins
   function automatic logic [15:0] sink_pattern(input logic [15:0] word, input logic off);
      logic [15:0] pat;
      pat = ~word;
      if (off) begin
         pat = SINK_RESET;
      end
      return pat;
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   // Gather the pins so one loop builds all four filters
   assign pin_raw[PIN_SCLK] = shift_clk_i;
   assign pin_raw[PIN_DATA] = serial_bit_in_i;
   assign pin_raw[PIN_STROBE] = latch_load_strobe_i;
   assign pin_raw[PIN_DISABLE] = output_disable_i;

   // Disable resets high so the sinks stay off until the host takes over;
   // the other filters reset low, the idle level of their pins
   for (genvar p = 0; p < PIN_COUNT; p++) begin : g_sync
      pin_sync #(
         .RESET_VAL((p == PIN_DISABLE) ? SYNC_HIGH_RESET : 1'b0)
      ) u_sync (
         .clk_i(clk_i),
         .rstn_i(rstn_i),
         .pin_i(pin_raw[p]),
         .level_o(pin_s[p])
      );
   end

   // ----------------------------------------
   // Edge detect
   // ----------------------------------------
   // Filtered levels under their own names
   assign sclk_s = pin_s[PIN_SCLK];
   assign data_s = pin_s[PIN_DATA];
   assign strobe_s = pin_s[PIN_STROBE];
   assign oe_n_s = pin_s[PIN_DISABLE];

   // Previous level resets low like the idle pin, so reset gives no false edge
   assign shift_edge = sclk_s & ~st_q.clk_prev;

   // ----------------------------------------
   // Shift, latch and output stage
   // ----------------------------------------
   // Data is filtered through the same depth as the clock, so it is sampled
   // with the level it had at the shift edge
   always_comb begin
      st_d = st_q;
      st_d.clk_prev = sclk_s;
      // Newest bit enters stage 0, the oldest drops off stage 15
      if (shift_edge) begin
         st_d.shift = {st_q.shift[14:0], data_s};
      end
      // Transparent latch modelled as a per-cycle load while strobe is high;
      // a shift in the same cycle passes straight through
      if (strobe_s) begin
         st_d.latch = st_d.shift;
      end
      // Registered copy of the oldest stage feeds the next device in a chain
      st_d.sout = st_d.shift[CHAN_COUNT-1];
      // Outputs are active low: a set latch bit sinks current when enabled
      st_d.sink_n = sink_pattern(st_d.latch, oe_n_s);
   end

   // State register; reset turns every sink off
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_q.clk_prev <= CLK_PREV_RESET;
         st_q.shift <= SHIFT_RESET;
         st_q.latch <= LATCH_RESET;
         st_q.sout <= SOUT_RESET;
         st_q.sink_n <= SINK_RESET;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Both outputs come straight from the state register
   assign serial_bit_out_o = st_q.sout;
   assign sink_on_n_o = st_q.sink_n;

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   // Shift register movement
   chk_shift_moves: assert property (@(posedge clk_i) disable iff (!rstn_i)
      shift_edge |=> st_q.shift[15:1] == $past(st_q.shift[14:0]) && st_q.shift[0] == $past(data_s))
      else $error("shift register did not advance on edge");

   chk_shift_holds: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !shift_edge |=> $stable(st_q.shift))
      else $error("shift register changed without edge");

   chk_edge_single: assert property (@(posedge clk_i) disable iff (!rstn_i)
      shift_edge |=> !shift_edge)
      else $error("one pin edge shifted twice");

   // Serial output
   chk_serial_out: assert property (@(posedge clk_i) disable iff (!rstn_i)
      serial_bit_out_o == st_q.shift[15])
      else $error("serial out is not oldest bit");

   chk_sout_follows: assert property (@(posedge clk_i) disable iff (!rstn_i)
      shift_edge |=> serial_bit_out_o == $past(st_q.shift[14]))
      else $error("serial out did not take stage 14 on edge");

   // Latch behaviour
   chk_latch_pass: assert property (@(posedge clk_i) disable iff (!rstn_i)
      strobe_s |=> st_q.latch == st_q.shift)
      else $error("latch not transparent while strobe high");

   chk_latch_hold: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !strobe_s |=> $stable(st_q.latch))
      else $error("latch changed while strobe low");

   chk_edge_through: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (strobe_s && shift_edge) |=> st_q.latch == {$past(st_q.shift[14:0]), $past(data_s)})
      else $error("shift during strobe did not pass through");

   // Output stage
   chk_all_off: assert property (@(posedge clk_i) disable iff (!rstn_i)
      oe_n_s |=> sink_on_n_o == SINK_RESET)
      else $error("outputs on while disabled");

   chk_disable_rise: assert property (@(posedge clk_i) disable iff (!rstn_i)
      $rose(oe_n_s) |=> sink_on_n_o == SINK_RESET)
      else $error("outputs not off after disable");

   chk_sink_on: assert property (@(posedge clk_i) disable iff (!rstn_i)
      !oe_n_s |=> sink_on_n_o == ~st_q.latch)
      else $error("enabled outputs differ from latch");

   chk_load_path: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (shift_edge && strobe_s && !oe_n_s) |=> sink_on_n_o[0] == ~$past(data_s))
      else $error("newest bit did not reach channel 0");

   chk_last_channel: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (strobe_s && !oe_n_s) |=> sink_on_n_o[15] == ~serial_bit_out_o)
      else $error("last channel differs from serial out");

   chk_all_channels: assert property (@(posedge clk_i) disable iff (!rstn_i)
      (strobe_s && !oe_n_s) |=> sink_on_n_o == ~st_q.shift)
      else $error("channels differ from shift stages");
endmodule

// file: dv/host_pin_model.sv
/*
 Host pin model: shifts a word first bit 15, pulses the strobe, drives enable.
 Assumes the bench clock and a device that samples its pins at 10 MHz.
*/
`timescale 1ns/1ps
module host_pin_model (
   // Clock
   input wire logic clk_i,
   // Pins to the device
   output logic shift_clk_o,
   output logic data_o,
   output logic strobe_o,
   output logic disable_o
);
   // ----------------------------------------
   // Pin drivers
   // ----------------------------------------
   // Outputs stay off until a known pattern is latched
   initial begin
      shift_clk_o = 1'b0;
      data_o = 1'b0;
      strobe_o = 1'b0;
      disable_o = 1'b1;
   end
   // Wait n edges, then move 10 ns past the edge
   task automatic hold(input int n);
      repeat (n) @(posedge clk_i);
      #10;
   endtask
   // Five cycles a phase: slow enough for the synchroniser, far under 30 MHz
   task automatic send(input logic [15:0] w, input logic latch);
      for (int i = 15; i >= 0; i--) begin
         data_o = w[i];
         hold(5);
         shift_clk_o = 1'b1;
         hold(5);
         shift_clk_o = 1'b0;
      end
      data_o = ~data_o; // Released data must not keep the last bit
      strobe_o = latch;
      hold(5);
      strobe_o = 1'b0;
      hold(5);
   endtask
   // Strobe level alone, for shifting with the latch left transparent
   task automatic set_strobe(input logic s);
      strobe_o = s;
      hold(5);
   endtask
   // Enable change, then time for it to reach the sinks
   task automatic set_disable(input logic off);
      disable_o = off;
      hold(8);
   endtask
endmodule

// file: dv/led_sink_shift_latch_bench.sv
/*
 Self-checking bench for the LED sink shift and latch block.
 Assumes the host pin model drives the four host pins; the bench drives clock and reset.
*/
`timescale 1ns/1ps
module led_sink_shift_latch_bench;
   logic clk_i = 1'b0;
   logic rstn_i = 1'b0;
   logic sclk;
   logic sdat;
   logic strb;
   logic dis;
   logic serial_bit_out_o;
   logic [15:0] sink_on_n_o;
   int miscompares = 0;
   int checked = 0;
   // Row: word shifted, sink pattern expected, serial out expected
   logic [32:0] rows [4] = '{{16'ha5c3, 16'h5a3c, 1'b1}, {16'h0001, 16'hfffe, 1'b0},
      {16'h8000, 16'h7fff, 1'b1}, {16'h1234, 16'hedcb, 1'b0}};
   // ----------------------------------------
   // Clock, host and device
   // ----------------------------------------
   initial forever #50 clk_i = ~clk_i;
   host_pin_model host (.clk_i(clk_i), .shift_clk_o(sclk), .data_o(sdat), .strobe_o(strb), .disable_o(dis));
   led_sink_shift_latch uut (.clk_i(clk_i), .rstn_i(rstn_i), .shift_clk_i(sclk), .serial_bit_in_i(sdat),
      .latch_load_strobe_i(strb), .output_disable_i(dis), .serial_bit_out_o(serial_bit_out_o),
      .sink_on_n_o(sink_on_n_o));
   // Words only; single bits go through check_bit
   task automatic check(input string n, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic check_bit(input string n, input logic e, input logic g);
      checked++;
      if (g !== e) begin
         miscompares++;
         $display("BAD %s expected %b seen %b", n, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Tests
   // ----------------------------------------
   // Rows first, then latch hold and enable cases
   initial begin
      repeat (8) @(posedge clk_i);
      #10;
      check("reset sink", 16'hffff, sink_on_n_o);
      check_bit("reset out", 1'b0, serial_bit_out_o);
      rstn_i = 1'b1;
      host.hold(4);
      foreach (rows[i]) begin
         host.send(rows[i][32:17], 1'b1);
         host.set_disable(1'b0);
         check("sink", rows[i][16:1], sink_on_n_o);
         check_bit("out", rows[i][0], serial_bit_out_o);
      end
      host.send(16'h00ff, 1'b0);
      check("held sink", 16'hedcb, sink_on_n_o);
      check_bit("new out", 1'b0, serial_bit_out_o);
      host.set_disable(1'b1);
      check("off sink", 16'hffff, sink_on_n_o);
      host.set_disable(1'b0);
      check("back sink", 16'hedcb, sink_on_n_o);
      // Shift with the strobe already high: bits pass straight to the sinks
      host.set_strobe(1'b1);
      host.send(16'h0003, 1'b1);
      check("pass sink", 16'hfffc, sink_on_n_o);
      check_bit("pass out", 1'b0, serial_bit_out_o);
      // Reset in mid-run turns every sink off and clears the latch
      rstn_i = 1'b0;
      host.hold(1);
      check("midreset sink", 16'hffff, sink_on_n_o);
      check_bit("midreset out", 1'b0, serial_bit_out_o);
      rstn_i = 1'b1;
      host.hold(6);
      check("after reset sink", 16'hffff, sink_on_n_o);
      end_of_test();
   end
   // About 0.11 ms of tests; the 3 ms limit, some 27 times that, means a hang
   initial begin
      #3000000;
      miscompares++;
      end_of_test();
   end
endmodule
